// >>> inc/ocdpc_pkg.sv
// constants and types for the second output channel divider/phase block
// assumes one input clock domain; half periods are carried as sample pairs
package ocdpc_pkg;

    // register offsets
    localparam logic [7:0] ADDR_DIV_LO = 8'h21;
    localparam logic [7:0] ADDR_DIV_HI = 8'h22;
    localparam logic [7:0] ADDR_PH_LO = 8'h23;
    localparam logic [7:0] ADDR_PH_HI = 8'h24;
    localparam logic [7:0] ADDR_DRV = 8'h25;
    localparam logic [7:0] ADDR_SE = 8'h26;

    // field widths
    localparam int DIV_W = 10;
    localparam int PH_W = 11;
    localparam int CNT_W = 11;

    // writable masks, reserved bits are zero
    localparam logic [7:0] MASK_DIV_HI = 8'h03;
    localparam logic [7:0] MASK_PH_HI = 8'h07;
    localparam logic [7:0] MASK_DRV = 8'hfe;
    localparam logic [7:0] MASK_SE = 8'hfc;

    // driver control fields
    localparam int PD_BIT = 7;
    localparam int SYNC_EXCL_BIT = 6;
    localparam int DPOL_LSB = 4;
    localparam int MODE_LSB = 1;

    // single-ended control fields
    localparam int PEN_BIT = 7;
    localparam int PPOL_LSB = 5;
    localparam int NEN_BIT = 4;
    localparam int NPOL_LSB = 2;

    // reset values
    localparam logic [7:0] RST_DIV_LO = 8'h00;
    localparam logic [7:0] RST_DIV_HI = 8'h00;
    localparam logic [7:0] RST_PH_LO = 8'h00;
    localparam logic [7:0] RST_PH_HI = 8'h00;
    localparam logic [7:0] RST_DRV = 8'h14;
    localparam logic [7:0] RST_SE = 8'h00;

    // modes 110 and 111 release the differential driver
    localparam logic [1:0] MODE_HIZ_TOP = 2'h3;

    typedef enum logic [1:0] {
        POL_HIGH = 2'h0,
        POL_NONINV = 2'h1,
        POL_INV = 2'h2,
        POL_LOW = 2'h3
    } ocdpc_pol_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h1,
        ST_DELAY = 3'h2,
        ST_RUN = 3'h4
    } ocdpc_state_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } ocdpc_req_t;

    typedef struct packed {
        ocdpc_state_t st;
        logic [CNT_W-1:0] dly;
        logic [CNT_W-1:0] pos;
        logic smp;
    } ocdpc_eng_t;

endpackage : ocdpc_pkg

// >>> verilog/ocdpc_sync2.sv
// two-flop synchroniser for one pin input
// assumes the pin is asynchronous to CLOCK
`timescale 1ns/1ns
module ocdpc_sync2 (
    // clock and control
    input wire logic clock,
    input wire logic rst_n,
    input wire logic ce,
    // level in and out
    input wire logic d,
    output logic q
);
    logic meta_reg;

    // the first stage feeds only the second
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            meta_reg <= 1'b0;
            q <= 1'b0;
        end else if (ce) begin
            meta_reg <= d;
            q <= meta_reg;
        end
    end
endmodule : ocdpc_sync2

// >>> verilog/ocdpc_leg.sv
// one output driver: polarity/force select on a half-period sample pair
// assumes samples come from the channel engine on the same clock
`timescale 1ns/1ns
module ocdpc_leg
    import ocdpc_pkg::*;
(
    // clock and control
    input wire logic clock,
    input wire logic rst_n,
    input wire logic ce,
    // sample pair and selection
    input wire logic [1:0] smp,
    input wire ocdpc_pol_t sel,
    input wire logic en,
    // driver
    output logic [1:0] pair,
    output logic oe_n
);
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            pair <= 2'h0;
        end else if (ce) begin
            case (sel)
                POL_HIGH: pair <= 2'h3;
                POL_NONINV: pair <= smp;
                POL_INV: pair <= ~smp;
                POL_LOW: pair <= 2'h0;
                default: pair <= 2'h0;
            endcase
        end
    end

    // output enable is low while the leg drives
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            oe_n <= 1'b1;
        end else if (ce) begin
            oe_n <= ~en;
        end
    end
endmodule : ocdpc_leg

// >>> verilog/ocdpc_top.sv
// second output channel: divider, half-period phase offset and drivers
// assumes the serial port decodes host frames into single-cycle register
// requests on CLOCK, and CLOCK is the input clock of the channel
// settings act live, so a write mid-period may cut one period short
// Overview of operation
// RULE_01: divider setting is 0x21 plus 0x22[1:0]
// RULE_02: output period is setting plus one inputs
// RULE_03: phase setting is 0x23 plus 0x24[2:0]
// RULE_04: output delayed by phase times half period
// RULE_05: bit 6 clear lets sync restart divider
// RULE_06: differential polarity: high, pass, invert, low
// RULE_07: three-bit driver mode, 11x releases differential
// RULE_08: bit 7 enables positive single-ended leg
// RULE_09: bits 6:5 set positive leg polarity
// RULE_10: bit 4 enables negative single-ended leg
// RULE_11: bits 3:2 set negative leg polarity
// RULE_12: host writes zero to reserved bits
// RULE_13: bit 7 of 0x25 stops the divider
`timescale 1ns/1ns
module ocdpc_top
    import ocdpc_pkg::*;
(
    // clock, reset, enable
    input wire logic CLOCK,
    input wire logic RST_N,
    input wire logic CE,
    // register port
    input wire ocdpc_req_t REG_REQ,
    output logic [7:0] REG_RDATA,
    // output sync pin
    input wire logic SYNC_REQ,
    // differential driver, pair is {first half, second half}
    output logic [1:0] SECOND_CLOCK_OUTPUT,
    output logic SECOND_CLOCK_OUTPUT_OE_N,
    output logic [2:0] DRIVER_MODE_SELECT,
    // single-ended legs
    output logic [1:0] SECOND_OUTPUT_POSITIVE_LEG,
    output logic SECOND_OUTPUT_POSITIVE_LEG_OE_N,
    output logic [1:0] SECOND_OUTPUT_NEGATIVE_LEG,
    output logic SECOND_OUTPUT_NEGATIVE_LEG_OE_N,
    // status
    output logic DIVIDER_RUNNING
);
    logic [7:0] div_lo_reg;
    logic [7:0] div_hi_reg;
    logic [7:0] ph_lo_reg;
    logic [7:0] ph_hi_reg;
    logic [7:0] drv_reg;
    logic [7:0] se_reg;

    logic [DIV_W-1:0] channel_divider_setting;
    logic [PH_W-1:0] channel_phase_setting;
    logic channel_divider_powerdown;
    logic channel_sync_exclude;
    ocdpc_pol_t differential_polarity_select;
    logic [2:0] driver_mode_select;
    logic positive_leg_single_ended_enable;
    ocdpc_pol_t positive_leg_polarity_select;
    logic negative_leg_single_ended_enable;
    ocdpc_pol_t negative_leg_polarity_select;

    logic [CNT_W-1:0] hi_len;
    logic [CNT_W-1:0] last_pos;
    logic sync_lvl;
    logic sync_lvl_d_reg;
    logic sync_rise;
    logic pd_d_reg;
    logic restart;
    ocdpc_eng_t eng_reg;
    ocdpc_eng_t eng_next;
    ocdpc_eng_t half_a;
    ocdpc_eng_t half_b;
    logic [1:0] smp_pair;
    logic pd_wake;
    logic wr_take;
    logic rd_take;

    // a request only counts on an enabled edge
    always_comb begin
        wr_take = CE && REG_REQ.wr;
        rd_take = CE && REG_REQ.rd;
    end

    // register writes; reserved bits are masked so they read zero
    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            div_lo_reg <= RST_DIV_LO;
            div_hi_reg <= RST_DIV_HI;
            ph_lo_reg <= RST_PH_LO;
            ph_hi_reg <= RST_PH_HI;
            drv_reg <= RST_DRV;
            se_reg <= RST_SE;
        end else if (wr_take) begin
            // RULE_12 reserved writes dropped
            case (REG_REQ.addr)
                ADDR_DIV_LO: div_lo_reg <= REG_REQ.wdata;
                ADDR_DIV_HI: div_hi_reg <= REG_REQ.wdata & MASK_DIV_HI;
                ADDR_PH_LO: ph_lo_reg <= REG_REQ.wdata;
                ADDR_PH_HI: ph_hi_reg <= REG_REQ.wdata & MASK_PH_HI;
                ADDR_DRV: drv_reg <= REG_REQ.wdata & MASK_DRV;
                ADDR_SE: se_reg <= REG_REQ.wdata & MASK_SE;
                default: ;
            endcase
        end
    end

    // read data is valid on the edge after the read request
    // reserved bits were never stored, so they read back as zero
    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            REG_RDATA <= 8'h00;
        end else if (rd_take) begin
            case (REG_REQ.addr)
                ADDR_DIV_LO: REG_RDATA <= div_lo_reg;
                ADDR_DIV_HI: REG_RDATA <= div_hi_reg;
                ADDR_PH_LO: REG_RDATA <= ph_lo_reg;
                ADDR_PH_HI: REG_RDATA <= ph_hi_reg;
                ADDR_DRV: REG_RDATA <= drv_reg;
                ADDR_SE: REG_RDATA <= se_reg;
                default: REG_RDATA <= 8'h00;
            endcase
        end
    end

    // divider and phase settings, each byte acts on its own
    always_comb begin
        // RULE_01 ten-bit divider setting
        channel_divider_setting = {div_hi_reg[1:0], div_lo_reg};
        // RULE_03 eleven-bit phase setting
        channel_phase_setting = {ph_hi_reg[2:0], ph_lo_reg};
    end

    // driver control fields
    always_comb begin
        channel_divider_powerdown = drv_reg[PD_BIT];
        channel_sync_exclude = drv_reg[SYNC_EXCL_BIT];
        differential_polarity_select = ocdpc_pol_t'(drv_reg[DPOL_LSB +: 2]);
        driver_mode_select = drv_reg[MODE_LSB +: 3];
    end

    // single-ended leg fields, independent of the driver mode
    always_comb begin
        positive_leg_single_ended_enable = se_reg[PEN_BIT];
        positive_leg_polarity_select = ocdpc_pol_t'(se_reg[PPOL_LSB +: 2]);
        negative_leg_single_ended_enable = se_reg[NEN_BIT];
        negative_leg_polarity_select = ocdpc_pol_t'(se_reg[NPOL_LSB +: 2]);
    end

    // RULE_02 division is setting plus one
    // period of 2*(n+1) half periods keeps odd ratios at 50 percent duty
    always_comb begin
        hi_len = {1'b0, channel_divider_setting} + 11'h001;
        last_pos = {channel_divider_setting, 1'b1};
    end

    ocdpc_sync2 u_sync (
        .clock(CLOCK),
        .rst_n(RST_N),
        .ce(CE),
        .d(SYNC_REQ),
        .q(sync_lvl)
    );

    // edge detect on the synchronised level only
    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            sync_lvl_d_reg <= 1'b0;
        end else if (CE) begin
            sync_lvl_d_reg <= sync_lvl;
        end
    end

    // power-down history, so waking up can restart the phase
    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            pd_d_reg <= 1'b0;
        end else if (CE) begin
            pd_d_reg <= channel_divider_powerdown;
        end
    end

    // RULE_05 excluded channel ignores sync
    // leaving power-down also restarts, so phase holds after wake-up
    always_comb begin
        sync_rise = sync_lvl && !sync_lvl_d_reg;
        pd_wake = pd_d_reg && !channel_divider_powerdown;
        restart = (sync_rise && !channel_sync_exclude) || pd_wake;
    end

    // one half period of the engine; delay halves are low
    function automatic ocdpc_eng_t half_step(
        input ocdpc_eng_t e,
        input logic [CNT_W-1:0] hl,
        input logic [CNT_W-1:0] lp
    );
        ocdpc_eng_t r;
        r = e;
        r.smp = 1'b0;
        case (e.st)
            ST_DELAY: begin
                if (e.dly != 11'h000) begin
                    r.dly = e.dly - 11'h001;
                end else begin
                    r.st = ST_RUN;
                    r.smp = (e.pos < hl);
                    r.pos = (e.pos >= lp) ? 11'h000 : e.pos + 11'h001;
                end
            end
            ST_RUN: begin
                r.smp = (e.pos < hl);
                // a shrunk setting must not strand the counter
                r.pos = (e.pos >= lp) ? 11'h000 : e.pos + 11'h001;
            end
            ST_IDLE: r.smp = 1'b0;
            default: r.st = ST_IDLE;
        endcase
        return r;
    endfunction : half_step

    // two half periods per clock cycle
    always_comb begin
        half_a = half_step(eng_reg, hi_len, last_pos);
        half_b = half_step(half_a, hi_len, last_pos);
        smp_pair = {half_a.smp, half_b.smp};
        eng_next = half_b;
        if (channel_divider_powerdown) begin
            // RULE_13 power-down stops the divider
            eng_next.st = ST_IDLE;
            eng_next.pos = 11'h000;
            eng_next.dly = 11'h000;
        end else if (restart) begin
            // RULE_04 delay in half input periods
            eng_next.st = ST_DELAY;
            eng_next.dly = channel_phase_setting;
            eng_next.pos = 11'h000;
        end
    end

    // reset lands in the delay state with no delay, so the clock starts at once
    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            eng_reg <= '{st: ST_DELAY, dly: 11'h000, pos: 11'h000, smp: 1'b0};
        end else if (CE) begin
            eng_reg <= eng_next;
        end
    end

    // status follows the state the engine is entering
    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            DIVIDER_RUNNING <= 1'b0;
        end else if (CE) begin
            DIVIDER_RUNNING <= (eng_next.st == ST_RUN);
        end
    end

    // RULE_07 mode code to the driver
    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            DRIVER_MODE_SELECT <= RST_DRV[MODE_LSB +: 3];
        end else if (CE) begin
            DRIVER_MODE_SELECT <= driver_mode_select;
        end
    end

    // all three drivers share one sample pair, so they stay aligned
    // RULE_06 differential polarity and force
    ocdpc_leg u_diff (
        .clock(CLOCK),
        .rst_n(RST_N),
        .ce(CE),
        .smp(smp_pair),
        .sel(differential_polarity_select),
        // RULE_07 codes 110 and 111 release it
        .en(driver_mode_select[2:1] != MODE_HIZ_TOP),
        .pair(SECOND_CLOCK_OUTPUT),
        .oe_n(SECOND_CLOCK_OUTPUT_OE_N)
    );

    // RULE_08 positive leg enable
    // RULE_09 positive leg polarity
    ocdpc_leg u_pos (
        .clock(CLOCK),
        .rst_n(RST_N),
        .ce(CE),
        .smp(smp_pair),
        .sel(positive_leg_polarity_select),
        .en(positive_leg_single_ended_enable),
        .pair(SECOND_OUTPUT_POSITIVE_LEG),
        .oe_n(SECOND_OUTPUT_POSITIVE_LEG_OE_N)
    );

    // RULE_10 negative leg enable
    // RULE_11 negative leg polarity
    ocdpc_leg u_neg (
        .clock(CLOCK),
        .rst_n(RST_N),
        .ce(CE),
        .smp(smp_pair),
        .sel(negative_leg_polarity_select),
        .en(negative_leg_single_ended_enable),
        .pair(SECOND_OUTPUT_NEGATIVE_LEG),
        .oe_n(SECOND_OUTPUT_NEGATIVE_LEG_OE_N)
    );

endmodule : ocdpc_top

// >>> bench/ocdpc_clk_sink.sv
// clock consumer: measures high and low runs of the half-period samples
// assumes pair is {first half, second half}, sampled on every rising clock
`timescale 1ns/1ns
module ocdpc_clk_sink (
    // clock
    input wire logic clock,
    // observed output
    input wire logic [1:0] pair,
    // last complete runs, in half periods
    output int hi_run,
    output int lo_run
);
    int run = 0;
    logic lvl = 1'b0;

    initial begin
        hi_run = 0;
        lo_run = 0;
    end

    always @(posedge clock) begin
        for (int i = 1; i >= 0; i--) begin
            if (pair[i] === lvl) begin
                run++;
            end else begin
                if (lvl) begin
                    hi_run = run;
                end else begin
                    lo_run = run;
                end
                lvl = pair[i];
                run = 1;
            end
        end
    end
endmodule : ocdpc_clk_sink

// >>> bench/ocdpc_props.sv
// concurrent checks on the ports of ocdpc_top
// assumes writes with CE low are dropped; a host-side shadow mirrors the writable bits of 0x25 and 0x26
`timescale 1ns/1ns
module ocdpc_props
    import ocdpc_pkg::*;
(
    // clock and reset
    input wire logic CLOCK,
    input wire logic RST_N,
    input wire logic CE,
    // register port
    input wire ocdpc_req_t REG_REQ,
    input wire logic [7:0] REG_RDATA,
    // outputs
    input wire logic [1:0] SECOND_CLOCK_OUTPUT,
    input wire logic SECOND_CLOCK_OUTPUT_OE_N,
    input wire logic [2:0] DRIVER_MODE_SELECT,
    input wire logic SECOND_OUTPUT_POSITIVE_LEG_OE_N,
    input wire logic SECOND_OUTPUT_NEGATIVE_LEG_OE_N,
    input wire logic DIVIDER_RUNNING
);
    logic [7:0] drv_reg;
    logic [7:0] se_reg;
    logic [2:0] age_reg;
    logic wr_now;
    assign wr_now = CE && REG_REQ.wr;

    // age saturates so outputs have settled after any write
    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            drv_reg <= RST_DRV;
            se_reg <= RST_SE;
            age_reg <= 3'h0;
        end else if (wr_now) begin
            age_reg <= 3'h0;
            if (REG_REQ.addr == ADDR_DRV) drv_reg <= REG_REQ.wdata & MASK_DRV;
            if (REG_REQ.addr == ADDR_SE) se_reg <= REG_REQ.wdata & MASK_SE;
        end else if (age_reg != 3'h7) begin
            age_reg <= age_reg + 3'h1;
        end
    end

    default clocking @(posedge CLOCK); endclocking
    default disable iff (!RST_N);

    a_mode_copy: assert property (wr_now && REG_REQ.addr == ADDR_DRV
        |-> ##2 DRIVER_MODE_SELECT == $past(REG_REQ.wdata[3:1], 2)) else $error("mode output wrong");
    a_read_back: assert property (CE && REG_REQ.rd && REG_REQ.addr == ADDR_DRV
        |=> REG_RDATA == $past(drv_reg)) else $error("read data wrong");
    a_hiz_release: assert property ($past(RST_N)
        |-> SECOND_CLOCK_OUTPUT_OE_N == (DRIVER_MODE_SELECT[2:1] == MODE_HIZ_TOP)) else $error("oe wrong");
    a_pd_stops: assert property (wr_now && REG_REQ.addr == ADDR_DRV && REG_REQ.wdata[PD_BIT]
        |-> ##[1:4] !DIVIDER_RUNNING) else $error("divider kept running");
    a_pd_quiet: assert property (age_reg == 3'h7 && drv_reg[7:4] == 4'h9
        |-> SECOND_CLOCK_OUTPUT == 2'h0) else $error("powered down output not low");
    a_force_high: assert property (age_reg == 3'h7 && drv_reg[5:4] == POL_HIGH
        |-> SECOND_CLOCK_OUTPUT == 2'h3) else $error("force high failed");
    a_force_low: assert property (age_reg == 3'h7 && drv_reg[5:4] == POL_LOW
        |-> SECOND_CLOCK_OUTPUT == 2'h0) else $error("force low failed");
    a_pos_enable: assert property (age_reg == 3'h7
        |-> SECOND_OUTPUT_POSITIVE_LEG_OE_N == !se_reg[PEN_BIT]) else $error("positive enable wrong");
    a_neg_enable: assert property (age_reg == 3'h7
        |-> SECOND_OUTPUT_NEGATIVE_LEG_OE_N == !se_reg[NEN_BIT]) else $error("negative enable wrong");
endmodule : ocdpc_props

bind ocdpc_top ocdpc_props ocdpc_props_i (.CLOCK(CLOCK), .RST_N(RST_N), .CE(CE), .REG_REQ(REG_REQ),
    .REG_RDATA(REG_RDATA), .SECOND_CLOCK_OUTPUT(SECOND_CLOCK_OUTPUT),
    .SECOND_CLOCK_OUTPUT_OE_N(SECOND_CLOCK_OUTPUT_OE_N), .DRIVER_MODE_SELECT(DRIVER_MODE_SELECT),
    .SECOND_OUTPUT_POSITIVE_LEG_OE_N(SECOND_OUTPUT_POSITIVE_LEG_OE_N),
    .SECOND_OUTPUT_NEGATIVE_LEG_OE_N(SECOND_OUTPUT_NEGATIVE_LEG_OE_N), .DIVIDER_RUNNING(DIVIDER_RUNNING));

// >>> bench/ocdpc_tb_top.sv
// self-checking bench for the second output channel
// CE low in one scenario; sink measures runs; drives land 1 ns after the rising edge
`timescale 1ns/1ns
module ocdpc_tb_top
    import ocdpc_pkg::*;
;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic sync_req = 1'b0;
    logic ce = 1'b1;
    ocdpc_req_t req = '0;
    logic [7:0] rdata;
    logic [7:0] v;
    logic [1:0] dout;
    logic [1:0] pout;
    logic [1:0] nout;
    logic doe_n;
    logic poe_n;
    logic noe_n;
    logic running;
    logic [2:0] mode;
    int hi_run;
    int lo_run;
    int error_cnt = 0;
    int samples_checked = 0;
    logic [7:0] adr [6] = '{ADDR_DIV_LO, ADDR_DIV_HI, ADDR_PH_LO, ADDR_PH_HI, ADDR_DRV, ADDR_SE};
    logic [7:0] rst [6] = '{RST_DIV_LO, RST_DIV_HI, RST_PH_LO, RST_PH_HI, RST_DRV, RST_SE};
    logic [7:0] msk [6] = '{8'hff, MASK_DIV_HI, 8'hff, MASK_PH_HI, MASK_DRV, MASK_SE};
    logic [9:0] dvs [4] = '{10'h0, 10'h1, 10'h4, 10'h3ff};
    logic [10:0] phs [3] = '{11'h1, 11'h4, 11'h7ff};

    always #4 clock = ~clock;

    ocdpc_top ocdpc_top_i (.CLOCK(clock), .RST_N(rst_n), .CE(ce), .REG_REQ(req), .REG_RDATA(rdata),
        .SYNC_REQ(sync_req), .SECOND_CLOCK_OUTPUT(dout), .SECOND_CLOCK_OUTPUT_OE_N(doe_n),
        .DRIVER_MODE_SELECT(mode), .SECOND_OUTPUT_POSITIVE_LEG(pout), .SECOND_OUTPUT_POSITIVE_LEG_OE_N(poe_n),
        .SECOND_OUTPUT_NEGATIVE_LEG(nout), .SECOND_OUTPUT_NEGATIVE_LEG_OE_N(noe_n), .DIVIDER_RUNNING(running));
    ocdpc_clk_sink ocdpc_clk_sink_i (.clock(clock), .pair(dout), .hi_run(hi_run), .lo_run(lo_run));

    task automatic chk(input string what, input logic [11:0] seen, input logic [11:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : cyc

    // one request, then an idle cycle so req is never set twice at once
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        cyc(1);
        req = '0;
        cyc(1);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        cyc(1);
        chk("read", 12'(rdata), 12'(exp));
        req = '0;
        cyc(1);
    endtask : rd

    task automatic wait_pair(input logic [1:0] p);
        for (int n = 0; n < 3000 && dout !== p; n++) cyc(1);
        chk("pair", 12'(dout), 12'(p));
    endtask : wait_pair

    function automatic logic [1:0] pol(input int c, input logic [1:0] x);
        case (c)
            0: return 2'h3;
            1: return x;
            2: return ~x;
            default: return 2'h0;
        endcase
    endfunction : pol

    task automatic give_verdict();
        $display("checks %0d errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : give_verdict

    initial begin
        repeat (40000) @(posedge clock);
        error_cnt++;
        give_verdict();
    end

    initial begin
        cyc(16);
        rst_n = 1'b1;
        for (int i = 0; i < 6; i++) begin
            rd(adr[i], rst[i]);
            wr(adr[i], msk[i]);
            rd(adr[i], msk[i]);
            wr(adr[i], rst[i]);
        end
        wr(8'h27, 8'hff);
        rd(8'h27, 8'h00);
        foreach (dvs[i]) begin
            wr(ADDR_DIV_LO, dvs[i][7:0]);
            wr(ADDR_DIV_HI, {6'h0, dvs[i][9:8]});
            cyc(4 * dvs[i] + 12);
            chk("high run", hi_run[11:0], 12'(dvs[i]) + 12'h1);
            chk("low run", lo_run[11:0], 12'(dvs[i]) + 12'h1);
        end
        // sync restart with phase delay in half periods
        wr(ADDR_DIV_LO, 8'h3f);
        wr(ADDR_DIV_HI, 8'h00);
        foreach (phs[i]) begin
            wr(ADDR_PH_LO, phs[i][7:0]);
            wr(ADDR_PH_HI, {5'h0, phs[i][10:8]});
            wait_pair(2'h0);
            wait_pair(2'h3);
            sync_req = 1'b1;
            cyc(3);
            sync_req = 1'b0;
            cyc(phs[i] / 2 + 12);
            chk("phase", lo_run[11:0], 12'(phs[i]));
        end
        wr(ADDR_DRV, RST_DRV | 8'h40);
        wait_pair(2'h0);
        wait_pair(2'h3);
        sync_req = 1'b1;
        cyc(3);
        sync_req = 1'b0;
        repeat (16) begin
            chk("masked", 12'(dout), 12'h3);
            cyc(1);
        end
        wr(ADDR_DRV, RST_DRV);
        wr(ADDR_PH_LO, 8'h00);
        wr(ADDR_PH_HI, 8'h00);
        wr(ADDR_DIV_LO, 8'h01);
        // polarity codes on all three drivers
        for (int c = 0; c < 4; c++) begin
            wr(ADDR_DRV, {2'h0, 2'(c), 3'h2, 1'b0});
            wr(ADDR_SE, 8'hb8);
            repeat (8) begin
                chk("diff", 12'(dout), 12'(pol(c, pout)));
                chk("neg inv", 12'(nout), 12'(pout ^ 2'h3));
                cyc(1);
            end
            wr(ADDR_DRV, RST_DRV);
            wr(ADDR_SE, {1'b1, 2'(c), 1'b1, 2'(c), 2'h0});
            repeat (4) begin
                chk("pos", 12'(pout), 12'(pol(c, dout)));
                chk("neg", 12'(nout), 12'(pol(c, dout)));
                cyc(1);
            end
        end
        // leg enables one at a time
        wr(ADDR_SE, 8'h80);
        chk("pos oe", 12'({poe_n, noe_n}), 12'h1);
        wr(ADDR_SE, 8'h10);
        chk("neg oe", 12'({poe_n, noe_n}), 12'h2);
        // clock enable low drops the write and holds the outputs
        ce = 1'b0;
        v = 8'(dout);
        wr(ADDR_SE, 8'h00);
        chk("frozen", 12'(dout), 12'(v));
        ce = 1'b1;
        rd(ADDR_SE, 8'h10);
        for (int m = 0; m < 8; m++) begin
            wr(ADDR_DRV, {4'h1, 3'(m), 1'b0});
            chk("mode", 12'(mode), 12'(m));
            chk("diff oe", 12'(doe_n), 12'(m > 5));
        end
        // power-down stops divider, forced code still forces
        wr(ADDR_DRV, RST_DRV | 8'h80);
        cyc(8);
        chk("stopped", 12'({running, dout}), 12'h0);
        wr(ADDR_DRV, 8'h84);
        cyc(2);
        chk("forced", 12'(dout), 12'h3);
        wr(ADDR_DRV, RST_DRV);
        cyc(4);
        chk("running", 12'(running), 12'h1);
        give_verdict();
    end
endmodule : ocdpc_tb_top
